// File: pkg/isp_defs.svh
`ifndef ISP_DEFS_SVH
`define ISP_DEFS_SVH

// register byte offsets
`define ISP_OFF_CTRL 8'h00
`define ISP_OFF_OWN 8'h04
`define ISP_OFF_DATA 8'h08
`define ISP_OFF_ACT 8'h0C
`define ISP_OFF_IEN 8'h10
`define ISP_OFF_RIS 8'h14
`define ISP_OFF_MIS 8'h18
`define ISP_OFF_ICLR 8'h1C

// control bits
`define ISP_CTRL_EN 0
`define ISP_CTRL_GIE 1

// interrupt source bits
`define ISP_INT_DATA 0
`define ISP_INT_START 1
`define ISP_INT_STOP 2

// action status codes
`define ISP_ACT_NONE 3'h0
`define ISP_ACT_RREQ 3'h1
`define ISP_ACT_TREQ 3'h2
`define ISP_ACT_FBR 3'h5

// one-hot state codes
`define ISP_S_IDLE 9'h001
`define ISP_S_ADDR 9'h002
`define ISP_S_AACK 9'h004
`define ISP_S_HOLD 9'h008
`define ISP_S_TX 9'h010
`define ISP_S_TACK 9'h020
`define ISP_S_RX 9'h040
`define ISP_S_RHOLD 9'h080
`define ISP_S_RACK 9'h100

`define ISP_BITS_DONE 4'h8
`define ISP_CNT_ONE 4'h1
`define ISP_CNT_ZERO 4'h0

`endif

// File: pkg/isp_pkg.sv
`default_nettype none
`include "isp_defs.svh"

package isp_pkg;
  typedef enum logic [8:0] {
    ST_IDLE = `ISP_S_IDLE,
    ST_ADDR = `ISP_S_ADDR,
    ST_AACK = `ISP_S_AACK,
    ST_HOLD = `ISP_S_HOLD,
    ST_TX = `ISP_S_TX,
    ST_TACK = `ISP_S_TACK,
    ST_RX = `ISP_S_RX,
    ST_RHOLD = `ISP_S_RHOLD,
    ST_RACK = `ISP_S_RACK
  } isp_state_t;

  typedef enum logic [2:0] {
    ACT_NONE = `ISP_ACT_NONE,
    ACT_RREQ = `ISP_ACT_RREQ,
    ACT_TREQ = `ISP_ACT_TREQ,
    ACT_FBR = `ISP_ACT_FBR
  } isp_act_t;
endpackage

`default_nettype wire

// File: hdl/isp_slave.sv
`default_nettype none
`include "isp_defs.svh"

module isp_slave
  import isp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // bus pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // interrupt
  output logic irq
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic [1:0] ctrl_reg;
  logic [6:0] own_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [2:0] ien_reg;
  logic [2:0] ris_reg;
  logic irq_reg;
  logic [31:0] rdata_reg;
  isp_state_t st_reg;
  isp_act_t act_reg;
  logic [7:0] sh_reg;
  logic [3:0] cnt_reg;
  logic rw_reg, first_reg, ack_ok_reg;
  logic sda_oe_reg, scl_oe_reg;
  logic [2:0] ev_reg;
  logic [1:0] scl_sync, sda_sync;
  logic scl_d, sda_d;

  logic en, rise, fall, start_c, stop_c, data_acc;
  logic [2:0] gate, mis;
  assign en = ctrl_reg[`ISP_CTRL_EN];
  assign rise = scl_sync[1] & ~scl_d;
  assign fall = ~scl_sync[1] & scl_d;
  assign start_c = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign stop_c = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
  assign data_acc = (wr | rd) & hit(addr, `ISP_OFF_DATA);
  assign gate = {ien_reg[`ISP_INT_STOP], ien_reg[`ISP_INT_START],
                 ien_reg[`ISP_INT_DATA] & ctrl_reg[`ISP_CTRL_GIE]};
  assign mis = ris_reg & gate;

  // two-stage synchronisers; only stage 2 feeds edge logic
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  // software registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= 2'h0;
      own_reg <= 7'h00;
      tx_reg <= 8'h00;
      ien_reg <= 3'h0;
    end else if (wr) begin
      if (hit(addr, `ISP_OFF_CTRL)) begin
        ctrl_reg <= wdata[1:0];
      end else if (hit(addr, `ISP_OFF_OWN)) begin
        own_reg <= wdata[6:0];
      end else if (hit(addr, `ISP_OFF_DATA)) begin
        tx_reg <= wdata[7:0];
      end else if (hit(addr, `ISP_OFF_IEN)) begin
        ien_reg <= wdata[2:0];
      end
    end
  end

  // sticky sources; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ris_reg <= 3'h0;
    end else begin
      if (wr && hit(addr, `ISP_OFF_ICLR)) begin
        ris_reg <= ev_reg;
      end else if (wr && hit(addr, `ISP_OFF_RIS)) begin
        ris_reg <= (ris_reg & ~wdata[2:0]) | ev_reg;
      end else begin
        ris_reg <= ris_reg | ev_reg;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |mis;
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd) begin
      if (hit(addr, `ISP_OFF_CTRL)) begin
        rdata_reg <= {30'h0, ctrl_reg};
      end else if (hit(addr, `ISP_OFF_OWN)) begin
        rdata_reg <= {25'h0, own_reg};
      end else if (hit(addr, `ISP_OFF_DATA)) begin
        rdata_reg <= {24'h0, rx_reg};
      end else if (hit(addr, `ISP_OFF_ACT)) begin
        rdata_reg <= {29'h0, act_reg};
      end else if (hit(addr, `ISP_OFF_IEN)) begin
        rdata_reg <= {29'h0, ien_reg};
      end else if (hit(addr, `ISP_OFF_RIS)) begin
        rdata_reg <= {29'h0, ris_reg};
      end else if (hit(addr, `ISP_OFF_MIS)) begin
        rdata_reg <= {29'h0, mis};
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // bus engine; action status lives here so a set beats a data-access clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg <= ST_IDLE;
      act_reg <= ACT_NONE;
      sh_reg <= 8'h00;
      rx_reg <= 8'h00;
      cnt_reg <= `ISP_CNT_ZERO;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      ev_reg <= 3'h0;
    end else begin
      ev_reg <= 3'h0;
      if (data_acc) begin
        act_reg <= ACT_NONE;
      end
      if (!en) begin
        st_reg <= ST_IDLE;
        sda_oe_reg <= 1'b0;
        scl_oe_reg <= 1'b0;
      end else if (start_c) begin
        st_reg <= ST_ADDR;
        cnt_reg <= `ISP_CNT_ZERO;
        first_reg <= 1'b1;
        sda_oe_reg <= 1'b0;
        scl_oe_reg <= 1'b0;
        ev_reg[`ISP_INT_START] <= 1'b1;
      end else if (stop_c) begin
        st_reg <= ST_IDLE;
        sda_oe_reg <= 1'b0;
        scl_oe_reg <= 1'b0;
        ev_reg[`ISP_INT_STOP] <= 1'b1;
      end else begin
        case (st_reg)
          ST_ADDR: begin
            if (rise) begin
              sh_reg <= {sh_reg[6:0], sda_sync[1]};
              cnt_reg <= cnt_reg + `ISP_CNT_ONE;
            end else if (fall && cnt_reg == `ISP_BITS_DONE) begin
              cnt_reg <= `ISP_CNT_ZERO;
              if (sh_reg[7:1] == own_reg) begin
                rw_reg <= sh_reg[0];
                sda_oe_reg <= 1'b1;
                st_reg <= ST_AACK;
              end else begin
                st_reg <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            if (fall) begin
              sda_oe_reg <= 1'b0;
              if (rw_reg) begin
                act_reg <= ACT_TREQ;
                ev_reg[`ISP_INT_DATA] <= 1'b1;
                scl_oe_reg <= 1'b1;
                st_reg <= ST_HOLD;
              end else begin
                st_reg <= ST_RX;
              end
            end
          end
          ST_HOLD: begin
            if (act_reg == ACT_NONE) begin
              sda_oe_reg <= ~tx_reg[7];
              sh_reg <= {tx_reg[6:0], 1'b0};
              cnt_reg <= `ISP_CNT_ONE;
              scl_oe_reg <= 1'b0;
              st_reg <= ST_TX;
            end
          end
          ST_TX: begin
            if (fall) begin
              if (cnt_reg == `ISP_BITS_DONE) begin
                sda_oe_reg <= 1'b0;
                cnt_reg <= `ISP_CNT_ZERO;
                st_reg <= ST_TACK;
              end else begin
                sda_oe_reg <= ~sh_reg[7];
                sh_reg <= {sh_reg[6:0], 1'b0};
                cnt_reg <= cnt_reg + `ISP_CNT_ONE;
              end
            end
          end
          ST_TACK: begin
            if (rise) begin
              ack_ok_reg <= ~sda_sync[1];
            end else if (fall) begin
              if (ack_ok_reg) begin
                act_reg <= ACT_TREQ;
                ev_reg[`ISP_INT_DATA] <= 1'b1;
                scl_oe_reg <= 1'b1;
                st_reg <= ST_HOLD;
              end else begin
                st_reg <= ST_IDLE;
              end
            end
          end
          ST_RX: begin
            if (rise) begin
              sh_reg <= {sh_reg[6:0], sda_sync[1]};
              cnt_reg <= cnt_reg + `ISP_CNT_ONE;
            end else if (fall && cnt_reg == `ISP_BITS_DONE) begin
              rx_reg <= sh_reg;
              cnt_reg <= `ISP_CNT_ZERO;
              act_reg <= first_reg ? ACT_FBR : ACT_RREQ;
              first_reg <= 1'b0;
              ev_reg[`ISP_INT_DATA] <= 1'b1;
              scl_oe_reg <= 1'b1;
              st_reg <= ST_RHOLD;
            end
          end
          ST_RHOLD: begin
            if (act_reg == ACT_NONE) begin
              sda_oe_reg <= 1'b1;
              scl_oe_reg <= 1'b0;
              st_reg <= ST_RACK;
            end
          end
          ST_RACK: begin
            if (fall) begin
              sda_oe_reg <= 1'b0;
              st_reg <= ST_RX;
            end
          end
          default: begin
            sda_oe_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // open drain: only ever drives low
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign sda_oe = sda_oe_reg;
  assign scl_oe = scl_oe_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_irq_follows: assert property (|(ris_reg & gate) |=> irq_reg)
    else $error("unmasked source did not raise irq");
  a_irq_disabled: assert property ((ien_reg == 3'h0) |=> !irq_reg)
    else $error("irq high with all sources disabled");
  a_data_gie_gate: assert property ((!ctrl_reg[`ISP_CTRL_GIE] && ris_reg[2:1] == 2'h0) |=> !irq_reg)
    else $error("data source passed with global enable clear");
  a_clear_all: assert property ((wr && hit(addr, `ISP_OFF_ICLR) && ev_reg == 3'h0) |=> ris_reg == 3'h0)
    else $error("clear-all left a source set");
  a_clear_one: assert property ((wr && hit(addr, `ISP_OFF_RIS) && wdata[0] && !ev_reg[0]) |=> !ris_reg[0])
    else $error("data source not cleared by mask");
  a_off_idle: assert property (!en |=> st_reg == ST_IDLE && !sda_oe_reg && !scl_oe_reg)
    else $error("disabled slave still on bus");
  a_addr_miss: assert property ((st_reg == ST_ADDR && en && !start_c && !stop_c && fall
      && cnt_reg == `ISP_BITS_DONE && sh_reg[7:1] != own_reg) |=> st_reg == ST_IDLE && !sda_oe_reg)
    else $error("acked foreign address");
  a_hold_clear: assert property ((st_reg == ST_HOLD && en && !start_c && !stop_c && wr
      && hit(addr, `ISP_OFF_DATA)) |=> act_reg == ACT_NONE
      ##1 st_reg == ST_TX && sda_oe_reg == ~$past(wdata[7], 2))
    else $error("written byte not driven after data write");
  a_rx_stretch: assert property ((st_reg == ST_RHOLD && act_reg != ACT_NONE) |-> scl_oe_reg)
    else $error("clock released before byte read");
  a_rx_request: assert property ((st_reg == ST_RX && en && !start_c && !stop_c && fall
      && cnt_reg == `ISP_BITS_DONE) |=> act_reg inside {ACT_RREQ, ACT_FBR} ##1 ris_reg[`ISP_INT_DATA])
    else $error("received byte raised no request");

  c_treq: cover property (st_reg == ST_HOLD ##[1:1000] st_reg == ST_TX);
  c_fbr: cover property (act_reg == ACT_FBR);
  c_rreq: cover property (act_reg == ACT_RREQ);
  c_irq: cover property ($rose(irq_reg));

endmodule

`default_nettype wire

// File: sim/isp_master_model.sv
`default_nettype none

module isp_master_model (
  // wire levels
  input wire logic scl,
  input wire logic sda,
  // open-drain pulls
  output logic scl_lo,
  output logic sda_lo
);
  timeunit 1ns;
  timeprecision 100ps;

  // pin changes are non-blocking so they never race the slave's sampling edge
  initial begin
    scl_lo <= 1'b0;
    sda_lo <= 1'b0;
  end

  // give up after 10 us so a stuck stretch shows as a miscompare, not a hang
  task automatic rise();
    int n;
    scl_lo <= 1'b0;
    for (n = 0; n < 400 && scl !== 1'b1; n++) #25;
  endtask

  // data moves well after the fall, since the slave sees edges ~3 clocks late
  task automatic put_bit(input logic b, output logic s);
    #100 sda_lo <= !b;
    #25 rise();
    #65 s = sda;
    #10 scl_lo <= 1'b1;
  endtask

  task automatic start();
    sda_lo <= 1'b1;
    #100 scl_lo <= 1'b1;
  endtask

  task automatic stop();
    #100 sda_lo <= 1'b1;
    #25 rise();
    #75 sda_lo <= 1'b0;
    #100;
  endtask

  // msb first, ninth bit left released for the ack
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask

  task automatic recv(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(!ack, s);
  endtask
endmodule

`default_nettype wire

// File: sim/i2c_slave_port_tb.sv
`default_nettype none
`include "isp_defs.svh"

module i2c_slave_port_tb;
  import isp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic scl_o, scl_oe, sda_o, sda_oe, irq, m_scl_lo, m_sda_lo;
  wire scl_w;
  wire sda_w;
  int miscompares = 0;
  int n_checks = 0;
  logic ack;
  logic [7:0] b;

  // pull-ups on both lines
  assign scl_w = (scl_oe ? scl_o : 1'b1) & !m_scl_lo;
  assign sda_w = (sda_oe ? sda_o : 1'b1) & !m_sda_lo;

  isp_slave uut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .irq(irq));
  isp_master_model m (.scl(scl_w), .sda(sda_w), .scl_lo(m_scl_lo), .sda_lo(m_sda_lo));

  initial begin
    forever #12.5 clk_sys = !clk_sys;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    chk(v, exp);
  endtask

  // polls the action register, bounded
  task automatic wait_act(input logic [31:0] exp);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 400 && v === 32'h0; i++) rd_reg(`ISP_OFF_ACT, v);
    chk(v, exp);
  endtask

  task automatic stop_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #500000;
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    chk_reg(`ISP_OFF_ACT, 32'h0);
    chk_reg(8'h20, 32'h0);
    wr_reg(`ISP_OFF_OWN, 32'h5A);
    wr_reg(`ISP_OFF_IEN, 32'h7);
    m.start();
    m.send(8'hB4, ack);
    m.stop();
    chk({31'h0, ack}, 32'h0);
    chk_reg(`ISP_OFF_RIS, 32'h0);
    wr_reg(`ISP_OFF_CTRL, 32'h3);
    m.start();
    m.send(8'hB6, ack);
    m.stop();
    chk({31'h0, ack}, 32'h0);
    chk_reg(`ISP_OFF_RIS, 32'h6);
    chk_reg(`ISP_OFF_MIS, 32'h6);
    chk({31'h0, irq}, 32'h1);
    wr_reg(`ISP_OFF_ICLR, 32'h1);
    chk_reg(`ISP_OFF_RIS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    m.start();
    fork
      begin
        m.send(8'hB4, ack);
        chk({31'h0, ack}, 32'h1);
        m.send(8'hA5, ack);
        m.send(8'h3C, ack);
        m.stop();
      end
      begin
        wait_act(32'(ACT_FBR));
        chk_reg(`ISP_OFF_DATA, 32'hA5);
        chk_reg(`ISP_OFF_ACT, 32'h0);
        wait_act(32'(ACT_RREQ));
        chk_reg(`ISP_OFF_DATA, 32'h3C);
      end
    join
    chk_reg(`ISP_OFF_RIS, 32'h7);
    m.start();
    fork
      begin
        m.send(8'hB5, ack);
        chk({31'h0, ack}, 32'h1);
        m.recv(1'b1, b);
        chk({24'h0, b}, 32'hC3);
        m.recv(1'b0, b);
        m.stop();
      end
      begin
        wait_act(32'(ACT_TREQ));
        wr_reg(`ISP_OFF_DATA, 32'hC3);
        chk_reg(`ISP_OFF_ACT, 32'h0);
        wait_act(32'(ACT_TREQ));
        wr_reg(`ISP_OFF_DATA, 32'h69);
        chk_reg(`ISP_OFF_ACT, 32'h0);
      end
    join
    chk({24'h0, b}, 32'h69);
    wr_reg(`ISP_OFF_RIS, 32'h2);
    chk_reg(`ISP_OFF_RIS, 32'h5);
    wr_reg(`ISP_OFF_IEN, 32'h1);
    chk_reg(`ISP_OFF_MIS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr_reg(`ISP_OFF_CTRL, 32'h1);
    chk_reg(`ISP_OFF_MIS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr_reg(`ISP_OFF_IEN, 32'h4);
    chk_reg(`ISP_OFF_MIS, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wr_reg(`ISP_OFF_RIS, 32'h1);
    chk_reg(`ISP_OFF_RIS, 32'h4);
    stop_test();
  end
endmodule

`default_nettype wire
